// file: shared/scfc_pkg.sv
// constants shared by the frequency-control device end and its host end
// assumes a single 200 MHz clock on both ends and the four-wire link in scfc_link_if
package scfc_pkg;
   localparam int unsigned CLK_MHZ = 200;
   localparam int unsigned XO_HZ_NOM = 30000000;
   localparam int unsigned XO_HZ_MIN = 25000000;
   localparam int unsigned XO_HZ_MAX = 32000000;
   localparam int unsigned XO_START_US = 250;
   localparam int unsigned XO_START_CYC_DEF = XO_START_US * CLK_MHZ;
   // 1 kHz conversion, inside the 300 Hz to 2.44 kHz window
   localparam int unsigned ADC_CONV_US = 1000;
   localparam int unsigned ADC_CONV_CYC_DEF = ADC_CONV_US * CLK_MHZ;
   localparam int unsigned SCK_HALF_NS = 80;
   localparam int unsigned SCK_HALF_CYC = (SCK_HALF_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned CNT_W = 18;
   localparam int unsigned FRAC_BITS = 19;
   localparam logic [26:0] FRAC_ONE = 27'h0080000;
   // commands
   localparam logic [7:0] CMD_NOP = 8'h00;
   localparam logic [7:0] CMD_SET_INT = 8'h01;
   localparam logic [7:0] CMD_FRAC_H = 8'h02;
   localparam logic [7:0] CMD_FRAC_M = 8'h03;
   localparam logic [7:0] CMD_FRAC_L = 8'h04;
   localparam logic [7:0] CMD_SET_BAND = 8'h05;
   localparam logic [7:0] CMD_SET_STEP = 8'h06;
   localparam logic [7:0] CMD_XO_TUNE = 8'h07;
   localparam logic [7:0] CMD_MODEM = 8'h08;
   localparam logic [7:0] CMD_START_RX = 8'h09;
   localparam logic [7:0] CMD_ADC_REQ = 8'h0A;
   localparam logic [7:0] CMD_READ_ADC = 8'h0B;
   localparam logic [7:0] CMD_READ_STAT = 8'h0C;
   // bands and output divider ratios
   localparam logic [1:0] BAND_LOW = 2'h0;
   localparam logic [1:0] BAND_MID = 2'h1;
   localparam logic [1:0] BAND_HIGH = 2'h2;
   localparam logic [3:0] OUTDIV_LOW = 4'hC;
   localparam logic [3:0] OUTDIV_MID = 4'h8;
   localparam logic [3:0] OUTDIV_HIGH = 4'h4;
   // modulation codes, modem byte and converter request fields
   localparam logic [1:0] MOD_OOK = 2'h0;
   localparam logic [1:0] MOD_FSK = 2'h1;
   localparam logic [1:0] MOD_GFSK = 2'h2;
   localparam int unsigned MODEM_MANCH_BIT = 2;
   localparam int unsigned ADC_EN_BATT_BIT = 0;
   localparam int unsigned ADC_EN_GPIO_BIT = 1;
   // host register offsets and fields
   localparam logic [4:0] REG_CMD = 5'h00;
   localparam logic [4:0] REG_PARAM = 5'h04;
   localparam logic [4:0] REG_STATUS = 5'h08;
   localparam logic [4:0] REG_RDATA = 5'h0C;
   localparam logic [4:0] REG_IRQ_STAT = 5'h10;
   localparam logic [4:0] REG_IRQ_MASK = 5'h14;
   localparam logic [4:0] REG_SHDN = 5'h18;
   localparam int unsigned CMD_PLEN_LSB = 8;
   localparam int unsigned CMD_RLEN_LSB = 10;
   localparam int unsigned IRQ_DONE_BIT = 0;
   localparam int unsigned IRQ_CTS_BIT = 1;
endpackage

// file: shared/scfc_link_if.sv
// four-wire serial link plus shutdown and command-done lines
// assumes the testbench resolves miso from miso and miso_oe
`timescale 1ns/10ps
interface scfc_link_if;
   logic sclk;
   logic mosi;
   logic nsel;
   logic shutdown_pin;
   logic miso;
   logic miso_oe;
   logic cts;
   modport dev (input sclk, input mosi, input nsel, input shutdown_pin, output miso, output miso_oe, output cts);
   modport host (output sclk, output mosi, output nsel, output shutdown_pin, input miso, input cts);
endinterface

// file: rtl/scfc_dev.sv
// device end: command decoder, synthesizer settings, channel tuning, trim, modem and aux converter
// assumes link pins arrive asynchronously and converter codes come from logic on clk
//
// Design decisions made here: the frame decoder and the status byte layout.
`timescale 1ns/10ps
module scfc_dev #(
   parameter int unsigned XO_HZ = scfc_pkg::XO_HZ_NOM,
   parameter int unsigned XO_START_CYC = scfc_pkg::XO_START_CYC_DEF,
   parameter int unsigned ADC_CONV_CYC = scfc_pkg::ADC_CONV_CYC_DEF
) (
   input wire logic clk,
   input wire logic nrst,
   scfc_link_if.dev link,
   input wire logic [10:0] batt_code,
   input wire logic [10:0] gpio_code,
   output logic [7:0] tuned_int,
   output logic [19:0] tuned_frac,
   output logic [31:0] tuned_hz,
   output logic [3:0] outdiv,
   output logic [6:0] xo_trim,
   output logic [1:0] mod_type,
   output logic manchester_en,
   output logic rx_active,
   output logic xo_ready,
   output logic [10:0] adc_result
);
   import scfc_pkg::*;

   typedef struct packed {
      logic [2:0] sck_s;
      logic [2:0] sel_s;
      logic [1:0] mosi_s;
      logic [1:0] sdn_s;
      logic [2:0] bitcnt;
      logic [1:0] bytecnt;
      logic [6:0] shreg;
      logic [7:0] cmd;
      logic [7:0] txsh;
      logic miso;
      logic miso_oe;
      logic [7:0] int_part;
      logic [19:0] frac_part;
      logic [1:0] band;
      logic [15:0] step;
      logic [7:0] chan;
      logic [26:0] sum;
      logic [7:0] tuned_int;
      logic [19:0] tuned_frac;
      logic [31:0] tuned_hz;
      logic [3:0] outdiv;
      logic [6:0] trim;
      logic [1:0] mod_type;
      logic manch;
      logic rx_on;
      logic [1:0] adc_en;
      logic adc_busy;
      logic [CNT_W-1:0] adc_cnt;
      logic [10:0] adc_res;
      logic [CNT_W-1:0] xo_cnt;
      logic xo_rdy;
      logic cts;
   } scfc_dev_s;

   scfc_dev_s st_ff;
   scfc_dev_s nxt_st;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [3:0] band_div(input logic [1:0] b);
      case (b)
         BAND_MID: band_div = OUTDIV_MID;
         BAND_HIGH: band_div = OUTDIV_HIGH;
         default: band_div = OUTDIV_LOW;
      endcase
   endfunction

   // base plus channel offset in fraction units; carry flows into the integer field
   function automatic logic [26:0] chan_sum(input logic [7:0] ip, input logic [19:0] fp, input logic [7:0] ch,
                                            input logic [15:0] stp);
      chan_sum = {ip, 19'h00000} + 27'(fp) + 27'(ch) * 27'(stp);
   endfunction

   // step resolution per band falls out of the 4/outdiv scaling here
   function automatic logic [31:0] sum_hz(input logic [26:0] s, input logic [1:0] b);
      logic [63:0] p;
      p = (64'(s) * 64'(XO_HZ)) >> (FRAC_BITS - 2);
      // divide by the full output ratio; the 4x of the loop is already in the shift above
      sum_hz = 32'(p / 64'(band_div(b)));
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic rise;
   logic fall;
   logic sel;
   logic byte_done;
   logic [7:0] rxb;
   logic [7:0] cur_cmd;
   logic [1:0] nidx;
   logic [7:0] resp;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.sck_s = {st_ff.sck_s[1:0], link.sclk};
      nxt_st.sel_s = {st_ff.sel_s[1:0], ~link.nsel};
      nxt_st.mosi_s = {st_ff.mosi_s[0], link.mosi};
      nxt_st.sdn_s = {st_ff.sdn_s[0], link.shutdown_pin};
      sel = st_ff.sel_s[1];
      rise = st_ff.sck_s[1] & ~st_ff.sck_s[2];
      fall = ~st_ff.sck_s[1] & st_ff.sck_s[2];
      rxb = {st_ff.shreg, st_ff.mosi_s[1]};
      byte_done = rise & sel & (st_ff.bitcnt == 3'h7);
      cur_cmd = (st_ff.bytecnt == 2'h0) ? rxb : st_ff.cmd;
      nidx = (st_ff.bytecnt == 2'h3) ? 2'h3 : st_ff.bytecnt + 2'h1;
      resp = 8'h00;
      if (cur_cmd == CMD_READ_ADC && nidx == 2'h1) begin
         resp = {5'h00, st_ff.adc_res[10:8]};
      end else if (cur_cmd == CMD_READ_ADC && nidx == 2'h2) begin
         resp = st_ff.adc_res[7:0];
      end else if (cur_cmd == CMD_READ_STAT && nidx == 2'h1) begin
         resp = {4'h0, st_ff.xo_rdy, st_ff.cts, st_ff.adc_busy, st_ff.rx_on};
      end
      nxt_st.miso_oe = sel;
      // frame start clears the decoder so an empty frame does nothing
      if (st_ff.sel_s[1] & ~st_ff.sel_s[2]) begin
         nxt_st.bitcnt = 3'h0;
         nxt_st.bytecnt = 2'h0;
         nxt_st.cmd = CMD_NOP;
         nxt_st.txsh = 8'h00;
      end else if (rise & sel) begin
         nxt_st.shreg = rxb[6:0];
         nxt_st.bitcnt = st_ff.bitcnt + 3'h1;
      end
      if (byte_done) begin
         nxt_st.bytecnt = nidx;
         nxt_st.txsh = resp;
         if (st_ff.bytecnt == 2'h0) begin
            nxt_st.cmd = rxb;
         end else begin
            case (st_ff.cmd)
               CMD_SET_INT: nxt_st.int_part = rxb;
               CMD_FRAC_H: nxt_st.frac_part[19:16] = rxb[3:0];
               CMD_FRAC_M: nxt_st.frac_part[15:8] = rxb;
               CMD_FRAC_L: nxt_st.frac_part[7:0] = rxb;
               CMD_SET_BAND: if (rxb[1:0] != 2'h3) nxt_st.band = rxb[1:0];
               CMD_SET_STEP: begin
                  if (st_ff.bytecnt == 2'h1) nxt_st.step[15:8] = rxb;
                  else if (st_ff.bytecnt == 2'h2) nxt_st.step[7:0] = rxb;
               end
               CMD_XO_TUNE: nxt_st.trim = rxb[6:0];
               CMD_MODEM: begin
                  if (rxb[1:0] != 2'h3) nxt_st.mod_type = rxb[1:0];
                  nxt_st.manch = rxb[MODEM_MANCH_BIT];
               end
               CMD_START_RX: if (st_ff.bytecnt == 2'h1) nxt_st.chan = rxb;
               CMD_ADC_REQ: if (st_ff.bytecnt == 2'h1) nxt_st.adc_en = rxb[1:0];
               default: ;
            endcase
         end
      end
      if (fall & sel) begin
         nxt_st.miso = st_ff.txsh[7];
         nxt_st.txsh = {st_ff.txsh[6:0], 1'b0};
      end
      // frame end acts on commands that start something
      if (~st_ff.sel_s[1] & st_ff.sel_s[2]) begin
         if (st_ff.cmd == CMD_START_RX) begin
            nxt_st.rx_on = 1'b1;
         end
         if (st_ff.cmd == CMD_ADC_REQ && st_ff.adc_en != 2'h0 && !st_ff.adc_busy) begin
            nxt_st.adc_busy = 1'b1;
            nxt_st.adc_cnt = CNT_W'(ADC_CONV_CYC - 1);
         end
      end
      if (st_ff.adc_busy) begin
         if (st_ff.adc_cnt == '0) begin
            nxt_st.adc_busy = 1'b0;
            nxt_st.adc_res = st_ff.adc_en[ADC_EN_GPIO_BIT] ? gpio_code : batt_code;
         end else begin
            nxt_st.adc_cnt = st_ff.adc_cnt - 1'b1;
         end
      end
      if (!st_ff.xo_rdy) begin
         if (st_ff.xo_cnt == CNT_W'(XO_START_CYC - 1)) begin
            nxt_st.xo_rdy = 1'b1;
         end else begin
            nxt_st.xo_cnt = st_ff.xo_cnt + 1'b1;
         end
      end
      // done line stays low until reference is up and results are in
      nxt_st.cts = nxt_st.xo_rdy & ~nxt_st.adc_busy;
      nxt_st.sum = chan_sum(st_ff.int_part, st_ff.frac_part, st_ff.chan, st_ff.step);
      // fraction field kept in 1..2, whole overflow moved to integer
      nxt_st.tuned_int = 8'((st_ff.sum - FRAC_ONE) >> FRAC_BITS);
      nxt_st.tuned_frac = {1'b1, st_ff.sum[18:0]};
      nxt_st.tuned_hz = sum_hz(st_ff.sum, st_ff.band);
      nxt_st.outdiv = band_div(st_ff.band);
      if (st_ff.sdn_s[1]) begin
         nxt_st = '0;
         nxt_st.sck_s = {st_ff.sck_s[1:0], link.sclk};
         nxt_st.sel_s = {st_ff.sel_s[1:0], ~link.nsel};
         nxt_st.mosi_s = {st_ff.mosi_s[0], link.mosi};
         nxt_st.sdn_s = {st_ff.sdn_s[0], link.shutdown_pin};
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign link.miso = st_ff.miso;
   assign link.miso_oe = st_ff.miso_oe;
   assign link.cts = st_ff.cts;
   assign tuned_int = st_ff.tuned_int;
   assign tuned_frac = st_ff.tuned_frac;
   assign tuned_hz = st_ff.tuned_hz;
   assign outdiv = st_ff.outdiv;
   assign xo_trim = st_ff.trim;
   assign mod_type = st_ff.mod_type;
   assign manchester_en = st_ff.manch;
   assign rx_active = st_ff.rx_on;
   assign xo_ready = st_ff.xo_rdy;
   assign adc_result = st_ff.adc_res;
endmodule

// file: rtl/scfc_host.sv
// host end: register port, frame sequencer, serial shifter and interrupt
// assumes the device end on the other side of scfc_link_if; miso and cts are asynchronous
`timescale 1ns/10ps
module scfc_host (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [4:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic irq,
   scfc_link_if.host link
);
   import scfc_pkg::*;

   typedef enum logic [2:0] {IDLE, WAIT_CTS, SETUP, XFER, HOLD} scfc_hst_e;

   typedef struct packed {
      scfc_hst_e state;
      logic [1:0] miso_s;
      logic [1:0] cts_s;
      logic cts_d;
      logic [7:0] cmd;
      logic [1:0] plen;
      logic [1:0] rlen;
      logic [23:0] param;
      logic [15:0] rbuf;
      logic [1:0] istat;
      logic [1:0] imask;
      logic shdn;
      logic [7:0] div;
      logic [2:0] idx;
      logic [2:0] bitn;
      logic [7:0] sh;
      logic sclk;
      logic mosi;
      logic nsel;
      logic irq;
      logic [31:0] rdata;
   } scfc_hst_s;

   scfc_hst_s st_ff;
   scfc_hst_s nxt_st;

   ////////////////////////////////////////////////////////////////////////////
   // byte 0 is the command, then parameters high first, then filler for reads
   function automatic logic [7:0] tx_byte(input scfc_hst_s s, input logic [2:0] i);
      logic [7:0] b;
      b = 8'h00;
      if (i == 3'h0) b = s.cmd;
      else if (i == 3'h1 && s.plen != 2'h0) b = s.param[23:16];
      else if (i == 3'h2 && s.plen > 2'h1) b = s.param[15:8];
      else if (i == 3'h3 && s.plen > 2'h2) b = s.param[7:0];
      if (s.cmd == CMD_FRAC_L && i == 3'h1) b[0] = 1'b1;
      tx_byte = b;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   logic [1:0] iset;
   logic [1:0] iclr;
   logic [2:0] last;
   logic half;
   logic [7:0] rxb;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.miso_s = {st_ff.miso_s[0], link.miso};
      nxt_st.cts_s = {st_ff.cts_s[0], link.cts};
      nxt_st.cts_d = st_ff.cts_s[1];
      iset = 2'h0;
      iset[IRQ_CTS_BIT] = st_ff.cts_s[1] & ~st_ff.cts_d;
      iclr = 2'h0;
      last = 3'(st_ff.plen) + 3'(st_ff.rlen);
      half = (st_ff.div == 8'(SCK_HALF_CYC - 1));
      rxb = {st_ff.sh[6:0], st_ff.miso_s[1]};
      nxt_st.div = half ? 8'h00 : st_ff.div + 8'h01;
      nxt_st.rdata = 32'h00000000;
      case (st_ff.state)
         IDLE: begin
            nxt_st.div = 8'h00;
            if (wr && addr == REG_CMD) begin
               nxt_st.cmd = wdata[7:0];
               nxt_st.plen = wdata[CMD_PLEN_LSB +: 2];
               nxt_st.rlen = wdata[CMD_RLEN_LSB +: 2];
               nxt_st.state = WAIT_CTS;
            end
         end
         // nothing goes out until the device reports its last command done
         WAIT_CTS: begin
            nxt_st.div = 8'h00;
            if (st_ff.cts_s[1]) begin
               nxt_st.nsel = 1'b0;
               nxt_st.idx = 3'h0;
               nxt_st.bitn = 3'h0;
               nxt_st.sh = tx_byte(st_ff, 3'h0);
               nxt_st.mosi = 1'(tx_byte(st_ff, 3'h0) >> 7);
               nxt_st.state = SETUP;
            end
         end
         SETUP: if (half) nxt_st.state = XFER;
         XFER: begin
            if (half && !st_ff.sclk) begin
               nxt_st.sclk = 1'b1;
            end else if (half) begin
               nxt_st.sclk = 1'b0;
               nxt_st.sh = rxb;
               nxt_st.bitn = st_ff.bitn + 3'h1;
               nxt_st.mosi = st_ff.sh[6];
               if (st_ff.bitn == 3'h7) begin
                  // read bytes follow the parameter bytes
                  if (st_ff.idx > 3'(st_ff.plen)) nxt_st.rbuf = {st_ff.rbuf[7:0], rxb};
                  nxt_st.idx = st_ff.idx + 3'h1;
                  nxt_st.sh = tx_byte(st_ff, st_ff.idx + 3'h1);
                  nxt_st.mosi = 1'(tx_byte(st_ff, st_ff.idx + 3'h1) >> 7);
                  if (st_ff.idx == last) nxt_st.state = HOLD;
               end
            end
         end
         HOLD: begin
            nxt_st.mosi = 1'b0;
            if (half && !st_ff.nsel) begin
               nxt_st.nsel = 1'b1;
            end else if (half) begin
               iset[IRQ_DONE_BIT] = 1'b1;
               nxt_st.state = IDLE;
            end
         end
         default: nxt_st.state = IDLE;
      endcase
      if (wr && addr == REG_PARAM) nxt_st.param = wdata[23:0];
      if (wr && addr == REG_IRQ_MASK) nxt_st.imask = wdata[1:0];
      if (wr && addr == REG_SHDN) nxt_st.shdn = wdata[0];
      if (wr && addr == REG_IRQ_STAT) iclr = wdata[1:0];
      // a new event beats a clear in the same cycle
      nxt_st.istat = (st_ff.istat & ~iclr) | iset;
      nxt_st.irq = |(nxt_st.istat & nxt_st.imask);
      if (rd) begin
         case (addr)
            REG_CMD: nxt_st.rdata = {20'h00000, st_ff.rlen, st_ff.plen, st_ff.cmd};
            REG_PARAM: nxt_st.rdata = {8'h00, st_ff.param};
            REG_STATUS: nxt_st.rdata = {29'h00000000, st_ff.shdn, st_ff.cts_s[1], st_ff.state != IDLE};
            REG_RDATA: nxt_st.rdata = {16'h0000, st_ff.rbuf};
            REG_IRQ_STAT: nxt_st.rdata = {30'h00000000, st_ff.istat};
            REG_IRQ_MASK: nxt_st.rdata = {30'h00000000, st_ff.imask};
            REG_SHDN: nxt_st.rdata = {31'h00000000, st_ff.shdn};
            default: nxt_st.rdata = 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_ff <= '0;
         st_ff.nsel <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign link.sclk = st_ff.sclk;
   assign link.mosi = st_ff.mosi;
   assign link.nsel = st_ff.nsel;
   assign link.shutdown_pin = st_ff.shdn;
   assign rdata = st_ff.rdata;
   assign irq = st_ff.irq;
endmodule

// file: testbench/scfc_monitor.sv
// concurrent checks on the four-wire link between the host end and the device end
// assumes one clock domain; the link signals of scfc_link_if arrive as plain inputs
`timescale 1ns/10ps
module scfc_monitor #(
   parameter int unsigned XO_START_CYC = 20
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic sclk,
   input wire logic mosi,
   input wire logic nsel,
   input wire logic shutdown_pin,
   input wire logic miso,
   input wire logic miso_oe,
   input wire logic cts
);
   logic [7:0] hi_ff;
   logic [7:0] lo_ff;
   logic [7:0] bits_ff;
   logic [31:0] up_ff;
   default clocking mon_cb @(posedge clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////////////////////////////////////////////
   // low count saturates so a long idle never wraps into a short one
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hi_ff <= 8'h00;
         lo_ff <= 8'h00;
         bits_ff <= 8'h00;
         up_ff <= 32'h0;
      end else begin
         hi_ff <= sclk ? hi_ff + 8'h01 : 8'h00;
         lo_ff <= sclk ? 8'h00 : ((lo_ff == 8'hFF) ? lo_ff : lo_ff + 8'h01);
         bits_ff <= nsel ? 8'h00 : bits_ff + {7'h00, sclk && (hi_ff == 8'h00)};
         up_ff <= shutdown_pin ? 32'h0 : up_ff + 32'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   idle_low_a: assert property (nsel |-> !sclk) else $error("link clock moved outside a frame");
   half_high_a: assert property ($fell(sclk) |-> hi_ff == 8'h10) else $error("clock high half wrong");
   half_low_a: assert property ($rose(sclk) |-> lo_ff >= 8'h10) else $error("clock low half too short");
   data_hold_a: assert property (sclk |-> $stable(mosi)) else $error("data moved while clock high");
   miso_hold_a: assert property (sclk |-> $stable(miso)) else $error("data back moved while clock high");
   sel_ready_a: assert property ($fell(nsel) |-> cts) else $error("frame opened without command done");
   whole_bytes_a: assert property ($rose(nsel) |-> bits_ff[2:0] == 3'h0 && bits_ff != 8'h00)
      else $error("frame not whole bytes");
   sel_close_a: assert property ($rose(nsel) |-> lo_ff >= 8'h10) else $error("select released too early");
   oe_idle_a: assert property (nsel [*4] |-> !miso_oe) else $error("data out driven while idle");
   oe_drive_a: assert property (!nsel [*4] |-> miso_oe) else $error("data out not driven in frame");
   xo_wait_a: assert property ($rose(cts) |-> up_ff >= XO_START_CYC)
      else $error("ready before reference start");
   shdn_clear_a: assert property (shutdown_pin [*6] |-> !cts) else $error("shutdown left command done high");
endmodule

// file: testbench/scfc_tb_top.sv
// self-checking bench: host end and device end joined by the link, driven through the host register port
// assumes the package constants and shortened start-up and conversion counts
`timescale 1ns/10ps
module scfc_tb_top;
   import scfc_pkg::*;
   localparam int unsigned XO = 25000000;
   localparam logic [31:0] BASE = 32'h014FFF01;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [4:0] addr = 5'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata;
   logic irq;
   logic [10:0] batt_code = 11'h5A3;
   logic [10:0] gpio_code = 11'h2C7;
   logic [7:0] tuned_int;
   logic [19:0] tuned_frac;
   logic [31:0] tuned_hz;
   logic [3:0] outdiv;
   logic [6:0] xo_trim;
   logic [1:0] mod_type;
   logic manchester_en;
   logic rx_active;
   logic xo_ready;
   logic [10:0] adc_result;
   logic [3:0] dv [4] = '{OUTDIV_LOW, OUTDIV_MID, OUTDIV_HIGH, OUTDIV_HIGH};
   int fail_count = 0;
   int compares = 0;
   scfc_link_if link();
   always #2.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   // short start-up and conversion counts keep the run well under the watchdog
   scfc_dev #(.XO_HZ(XO), .XO_START_CYC(20), .ADC_CONV_CYC(30)) scfc_dev_i (.clk(clk), .nrst(nrst), .link(link.dev),
      .batt_code(batt_code), .gpio_code(gpio_code), .tuned_int(tuned_int), .tuned_frac(tuned_frac),
      .tuned_hz(tuned_hz), .outdiv(outdiv), .xo_trim(xo_trim), .mod_type(mod_type), .manchester_en(manchester_en),
      .rx_active(rx_active), .xo_ready(xo_ready), .adc_result(adc_result));
   scfc_host scfc_host_i (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .irq(irq), .link(link.host));
   scfc_monitor #(.XO_START_CYC(20)) scfc_monitor_i (.clk(clk), .nrst(nrst), .sclk(link.sclk), .mosi(link.mosi),
      .nsel(link.nsel), .shutdown_pin(link.shutdown_pin), .miso(link.miso), .miso_oe(link.miso_oe), .cts(link.cts));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // bounded so a frame that never closes ends as a mismatch, not a hang
   task automatic wait_done();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 4000) begin
         @(posedge clk);
         n++;
      end
      chk("frame done", 32'h1, {31'h0, irq});
   endtask
   task automatic frame(input logic [7:0] c, input logic [1:0] pl, input logic [1:0] rl, input logic [23:0] p);
      wr_reg(REG_PARAM, {8'h00, p});
      wr_reg(REG_CMD, {20'h0, rl, pl, c});
      wait_done();
      wr_reg(REG_IRQ_STAT, 32'h3);
   endtask
   task automatic tune_chk(input logic [31:0] s, input int k);
      logic [63:0] hz;
      hz = (64'(s) * 64'(XO)) >> 17;
      hz = hz / k;
      chk("tuned_int", {24'h0, s[26:19] - 8'h01}, {24'h0, tuned_int});
      chk("tuned_frac", {12'h0, 1'b1, s[18:0]}, {12'h0, tuned_frac});
      chk("tuned_hz", hz[31:0], tuned_hz);
   endtask
   // fraction low byte sent as zero: the host end must force its lsb
   task automatic set_base();
      frame(CMD_SET_INT, 2'h1, 2'h0, 24'h280000);
      frame(CMD_FRAC_H, 2'h1, 2'h0, 24'h0F0000);
      frame(CMD_FRAC_M, 2'h1, 2'h0, 24'hFF0000);
      frame(CMD_FRAC_L, 2'h1, 2'h0, 24'h000000);
      frame(CMD_SET_STEP, 2'h2, 2'h0, 24'h010000);
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (80000) @(posedge clk);
      fail_count++;
      conclude();
   end
   initial begin
      logic [31:0] v;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      chk("rx_active", 32'h0, {31'h0, rx_active});
      wr_reg(REG_IRQ_MASK, 32'h1);
      for (int b = 0; b < 4; b++) begin
         frame(CMD_SET_BAND, 2'h1, 2'h0, {b[7:0], 16'h0});
         chk("outdiv", {28'h0, dv[b]}, {28'h0, outdiv});
      end
      set_base();
      chk("xo_ready", 32'h1, {31'h0, xo_ready});
      tune_chk(BASE, OUTDIV_HIGH);
      frame(CMD_START_RX, 2'h1, 2'h0, 24'h050000);
      tune_chk(BASE + 32'h500, OUTDIV_HIGH);
      frame(CMD_START_RX, 2'h0, 2'h0, 24'h0);
      tune_chk(BASE + 32'h500, OUTDIV_HIGH);
      frame(CMD_START_RX, 2'h1, 2'h0, 24'h0);
      tune_chk(BASE, OUTDIV_HIGH);
      chk("rx_active", 32'h1, {31'h0, rx_active});
      for (int b = 0; b < 2; b++) begin
         frame(CMD_SET_BAND, 2'h1, 2'h0, {b[7:0], 16'h0});
         tune_chk(BASE, dv[b]);
      end
      frame(CMD_XO_TUNE, 2'h1, 2'h0, 24'h7F0000);
      chk("xo_trim", 32'h7F, {25'h0, xo_trim});
      for (int m = 0; m < 4; m++) begin
         frame(CMD_MODEM, 2'h1, 2'h0, {5'h0, m[0], m[1:0], 16'h0});
         chk("mod_type", (m == 3) ? 32'h2 : m, {30'h0, mod_type});
         if (m < 3) begin
            chk("manchester_en", {31'h0, m[0]}, {31'h0, manchester_en});
         end
      end
      for (int i = 0; i < 2; i++) begin
         frame(CMD_ADC_REQ, 2'h1, 2'h0, {(i == 0) ? 8'h01 : 8'h03, 16'h0});
         rd_reg(REG_STATUS, v);
         chk("ready during conversion", 32'h0, {31'h0, v[1]});
         frame(CMD_READ_ADC, 2'h0, 2'h2, 24'h0);
         rd_reg(REG_RDATA, v);
         chk("converter bytes", {21'h0, (i == 0) ? batt_code : gpio_code}, {16'h0, v[15:0]});
         chk("adc_result", {21'h0, (i == 0) ? batt_code : gpio_code}, {21'h0, adc_result});
      end
      frame(CMD_READ_STAT, 2'h0, 2'h1, 24'h0);
      rd_reg(REG_RDATA, v);
      chk("status byte", 32'h0D, {24'h0, v[7:0]});
      wr_reg(REG_CMD, {24'h0, CMD_NOP});
      wait_done();
      wr_reg(REG_IRQ_MASK, 32'h0);
      @(posedge clk);
      #1 chk("masked irq", 32'h0, {31'h0, irq});
      rd_reg(REG_IRQ_STAT, v);
      chk("done status", 32'h1, {31'h0, v[0]});
      wr_reg(REG_IRQ_MASK, 32'h1);
      @(posedge clk);
      #1 chk("unmasked irq", 32'h1, {31'h0, irq});
      wr_reg(REG_IRQ_STAT, 32'h3);
      @(posedge clk);
      #1 chk("cleared irq", 32'h0, {31'h0, irq});
      rd_reg(5'h1C, v);
      chk("unmapped read", 32'h0, v);
      wr_reg(REG_SHDN, 32'h1);
      repeat (6) @(posedge clk);
      #1 chk("rx_active", 32'h0, {31'h0, rx_active});
      chk("xo_trim", 32'h0, {25'h0, xo_trim});
      chk("xo_ready", 32'h0, {31'h0, xo_ready});
      wr_reg(REG_SHDN, 32'h0);
      repeat (40) @(posedge clk);
      rd_reg(REG_IRQ_STAT, v);
      chk("ready event", 32'h1, {31'h0, v[IRQ_CTS_BIT]});
      set_base();
      frame(CMD_START_RX, 2'h0, 2'h0, 24'h0);
      tune_chk(BASE, OUTDIV_LOW);
      conclude();
   end
endmodule
